// ### rtl/gpp_pkg.sv
// Package: register map, reset values and shared types for the gpio port
package gpp_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_DATA_HI = 12'h3fc;
    localparam logic [11:0] OFS_DIR = 12'h400;
    localparam logic [11:0] OFS_SENSE = 12'h404;
    localparam logic [11:0] OFS_DUAL = 12'h408;
    localparam logic [11:0] OFS_POL = 12'h40c;
    localparam logic [11:0] OFS_MASK = 12'h410;
    localparam logic [11:0] OFS_RAW = 12'h414;
    localparam logic [11:0] OFS_MSTAT = 12'h418;
    localparam logic [11:0] OFS_CLR = 12'h41c;
    localparam logic [11:0] OFS_AFSEL = 12'h420;
    localparam logic [11:0] OFS_DRV2 = 12'h500;
    localparam logic [11:0] OFS_DRV4 = 12'h504;
    localparam logic [11:0] OFS_DRV8 = 12'h508;
    localparam logic [11:0] OFS_ODR = 12'h50c;
    localparam logic [11:0] OFS_PUR = 12'h510;
    localparam logic [11:0] OFS_PDR = 12'h514;
    localparam logic [11:0] OFS_SLR = 12'h518;
    localparam logic [11:0] OFS_DEN = 12'h51c;
    localparam logic [11:0] OFS_LOCK = 12'h520;
    localparam logic [11:0] OFS_COMMIT = 12'h524;
    localparam logic [11:0] OFS_ID_BASE = 12'hfd0;
    localparam int unsigned DATA_MASK_LSB = 2;
    localparam logic [7:0] RST_DRV2 = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Unlock key is arbitrary
    localparam logic [31:0] UNLOCK_KEY = 32'h1ac0_c0de;
    localparam logic [31:0] LOCKED_VAL = 32'h0000_0001;
    localparam int unsigned ADC_TRIG_BIT = 4;
    typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} gpp_bus_st_t;
endpackage

// ### rtl/gpp_if.sv
// Interface between the port top and its interrupt detector
interface gpp_irq_if #(parameter int W = 8);
    logic [W-1:0] pin_sync;
    logic [W-1:0] sense;
    logic [W-1:0] dual;
    logic [W-1:0] pol;
    logic [W-1:0] clr;
    logic [W-1:0] raw;
    modport ctl (output pin_sync, output sense, output dual, output pol, output clr, input raw);
    modport det (input pin_sync, input sense, input dual, input pol, input clr, output raw);
endinterface

// ### rtl/gpp_irq_detect.sv
// Per-pin interrupt detector: edge/level, polarity, both edges, sticky edge status
module gpp_irq_detect #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic srst,
    gpp_irq_if.det irq
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] latch;
    } gpp_det_st_t;
    gpp_det_st_t st_r, st_nxt;
    logic [W-1:0] rise, fall, hit, lvl;
    always_comb begin
        st_nxt = st_r;
        rise = irq.pin_sync & ~st_r.prev;
        fall = ~irq.pin_sync & st_r.prev;
        hit = irq.dual & (rise | fall) | ~irq.dual & (irq.pol & rise | ~irq.pol & fall);
        lvl = irq.pin_sync & irq.pol | ~irq.pin_sync & ~irq.pol;
        st_nxt.prev = irq.pin_sync;
        // Set beats clear in the same cycle so no edge is lost
        st_nxt.latch = (st_r.latch & ~irq.clr | hit) & ~irq.sense;
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign irq.raw = irq.sense & lvl | ~irq.sense & st_r.latch;
endmodule // gpp_irq_detect

// ### rtl/gpp_port.sv
// Eight-pin gpio port with interrupts, mode select, commit lock and pad control
// Notes on behaviour
// - All unmasked pin conditions combine into one port interrupt output.
// - Edge events stay latched in raw status until software clears them.
// - Sense 0 edge, 1 level; dual-edge 0 single, 1 both edges.
// - Polarity 0 low/falling, 1 high/rising; ignored for edges in dual mode.
// - Mask 0 blocks a pin from the interrupt output, 1 passes it.
// - Raw status shows met trigger conditions regardless of mask.
// - Masked status is raw status ANDed with the mask.
// - Writing 1 to clear clears that latched bit; 0 leaves it.
// - Unmasked trigger pin also raises an ADC trigger pulse.
// - Alternate function 1 routes pin out, enable and input to the peripheral.
// - Alternate function 0 drives and reads pins through the data register.
// - Protected select bits change only when unlocked and commit enabled.
// - Drive 2/4/8 mA, open drain, pulls, slew and digital enable reach pad.
// - Reset leaves pins undriven, except protected debug pins in their defaults.
// - Eight peripheral and four cell identification words read only.
// - Digital input works with digital enable set; analog needs all zero.
// - Data access uses address bits 9:2 as per-bit write and read mask.
// - Direction 0 captures pin input, direction 1 drives data register bit when digital enable is set.
//
// The address map and register access over Avalon-MM were decided locally.
module gpp_port #(
    parameter int W = 8,
    parameter logic [7:0] RST_AFSEL = 8'h00,
    parameter logic [7:0] RST_PUR = 8'h00,
    parameter logic [7:0] RST_DEN = 8'h00,
    parameter logic [7:0] RST_COMMIT = 8'hff,
    parameter bit HAS_ADC_TRIG = 1'b0,
    // Identification words are arbitrary
    parameter logic [95:0] IDENT = 96'h0
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    input wire logic [W-1:0] alt_out,
    input wire logic [W-1:0] alt_oe,
    output logic [W-1:0] alt_in,
    output logic [W-1:0] pad_drive_low,
    output logic [W-1:0] pad_drive_mid,
    output logic [W-1:0] pad_drive_high,
    output logic [W-1:0] pad_open_drain,
    output logic [W-1:0] pad_pull_up,
    output logic [W-1:0] pad_pull_down,
    output logic [W-1:0] pad_slew_limit,
    output logic [W-1:0] pad_digital_enable,
    output logic port_irq,
    output logic adc_trigger
);
    initial begin
        if (W != 8) $error("gpp_port supports W = 8 only");
    end
    typedef struct packed {
        gpp_pkg::gpp_bus_st_t bus;
        logic [31:0] rdata;
        logic [W-1:0] sync1, sync2;
        logic [W-1:0] data, dir, sense, dual, pol, mask, clr;
        logic [W-1:0] afsel, drv2, drv4, drv8, odr, pur, pdr, slr, den, commit;
        logic locked;
        logic [W-1:0] pin_out, pin_oe, alt_in;
        logic irq, adc, adc_prev;
    } gpp_st_t;
    gpp_st_t st_r, st_nxt;
    logic [W-1:0] raw, msk, ain, pin_val, wmask;
    logic [31:0] rd;
    logic [11:0] a;
    logic [3:0] id_idx;
    logic wr;
    gpp_irq_if #(.W(W)) irq_bus ();
    assign irq_bus.pin_sync = st_r.sync2;
    assign irq_bus.sense = st_r.sense;
    assign irq_bus.dual = st_r.dual;
    assign irq_bus.pol = st_r.pol;
    assign irq_bus.clr = st_r.clr;
    assign raw = irq_bus.raw;
    gpp_irq_detect #(.W(W)) u_det (
        .core_clk(core_clk),
        .srst(srst),
        .irq(irq_bus)
    );
    always_comb begin
        st_nxt = st_r;
        a = avs_address;
        // Identification words count from the base; a[5:2] is 4 at 0xfd0, so subtracting 4 maps 0xfd0 to word 0
        id_idx = a[5:2] - 4'h4;
        // Writes land on the edge that sees waitrequest low, as the master expects
        wr = avs_write && st_r.bus == gpp_pkg::BUS_ACK;
        msk = raw & st_r.mask;
        // Digital input disabled reads as zero, leaving the pad free for analog
        ain = st_r.sync2 & st_r.den;
        pin_val = (st_r.data & st_r.dir) | (ain & ~st_r.dir);
        wmask = a[gpp_pkg::DATA_MASK_LSB +: 8];
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.clr = '0;
        // Input pins keep capturing the pin value into the data register
        st_nxt.data = (st_r.data & st_r.dir) | (ain & ~st_r.dir);
        rd = 32'h0;
        if (a <= gpp_pkg::OFS_DATA_HI) begin
            rd = {24'h0, pin_val & wmask};
        end else if (a == gpp_pkg::OFS_DIR) begin
            rd = {24'h0, st_r.dir};
        end else if (a == gpp_pkg::OFS_SENSE) begin
            rd = {24'h0, st_r.sense};
        end else if (a == gpp_pkg::OFS_DUAL) begin
            rd = {24'h0, st_r.dual};
        end else if (a == gpp_pkg::OFS_POL) begin
            rd = {24'h0, st_r.pol};
        end else if (a == gpp_pkg::OFS_MASK) begin
            rd = {24'h0, st_r.mask};
        end else if (a == gpp_pkg::OFS_RAW) begin
            rd = {24'h0, raw};
        end else if (a == gpp_pkg::OFS_MSTAT) begin
            rd = {24'h0, msk};
        end else if (a == gpp_pkg::OFS_AFSEL) begin
            rd = {24'h0, st_r.afsel};
        end else if (a == gpp_pkg::OFS_DRV2) begin
            rd = {24'h0, st_r.drv2};
        end else if (a == gpp_pkg::OFS_DRV4) begin
            rd = {24'h0, st_r.drv4};
        end else if (a == gpp_pkg::OFS_DRV8) begin
            rd = {24'h0, st_r.drv8};
        end else if (a == gpp_pkg::OFS_ODR) begin
            rd = {24'h0, st_r.odr};
        end else if (a == gpp_pkg::OFS_PUR) begin
            rd = {24'h0, st_r.pur};
        end else if (a == gpp_pkg::OFS_PDR) begin
            rd = {24'h0, st_r.pdr};
        end else if (a == gpp_pkg::OFS_SLR) begin
            rd = {24'h0, st_r.slr};
        end else if (a == gpp_pkg::OFS_DEN) begin
            rd = {24'h0, st_r.den};
        end else if (a == gpp_pkg::OFS_LOCK) begin
            rd = {31'h0, st_r.locked};
        end else if (a == gpp_pkg::OFS_COMMIT) begin
            rd = {24'h0, st_r.commit};
        end else if (a >= gpp_pkg::OFS_ID_BASE && a[1:0] == 2'h0) begin
            rd = {24'h0, IDENT[8*(11-id_idx) +: 8]};
        end
        if (wr) begin
            if (a <= gpp_pkg::OFS_DATA_HI) begin
                // Input bits are overwritten by capture on the next cycle; the written value is gone when they turn output
                st_nxt.data = (st_r.data & ~wmask & st_r.dir) | (ain & ~st_r.dir & ~wmask)
                    | (avs_writedata[7:0] & wmask);
            end else if (a == gpp_pkg::OFS_DIR) begin
                st_nxt.dir = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_SENSE) begin
                st_nxt.sense = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_DUAL) begin
                st_nxt.dual = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_POL) begin
                st_nxt.pol = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_MASK) begin
                st_nxt.mask = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_CLR) begin
                st_nxt.clr = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_AFSEL) begin
                // Protected bits hold unless unlocked and commit-enabled
                st_nxt.afsel = (st_r.afsel & ~(st_r.commit & {W{~st_r.locked}}))
                    | (avs_writedata[7:0] & st_r.commit & {W{~st_r.locked}});
            end else if (a == gpp_pkg::OFS_DRV2) begin
                st_nxt.drv2 = avs_writedata[7:0];
                st_nxt.drv4 = st_r.drv4 & ~avs_writedata[7:0];
                st_nxt.drv8 = st_r.drv8 & ~avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_DRV4) begin
                st_nxt.drv4 = avs_writedata[7:0];
                st_nxt.drv2 = st_r.drv2 & ~avs_writedata[7:0];
                st_nxt.drv8 = st_r.drv8 & ~avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_DRV8) begin
                st_nxt.drv8 = avs_writedata[7:0];
                st_nxt.drv2 = st_r.drv2 & ~avs_writedata[7:0];
                st_nxt.drv4 = st_r.drv4 & ~avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_ODR) begin
                st_nxt.odr = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_PUR) begin
                st_nxt.pur = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_PDR) begin
                st_nxt.pdr = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_SLR) begin
                st_nxt.slr = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_DEN) begin
                st_nxt.den = avs_writedata[7:0];
            end else if (a == gpp_pkg::OFS_LOCK) begin
                st_nxt.locked = avs_writedata != gpp_pkg::UNLOCK_KEY;
            end else if (a == gpp_pkg::OFS_COMMIT) begin
                if (!st_r.locked) begin
                    st_nxt.commit = avs_writedata[7:0];
                end
            end
        end
        case (st_r.bus)
            gpp_pkg::BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    st_nxt.bus = gpp_pkg::BUS_ACK;
                    // Read data only move on a read, so a write leaves the last value standing
                    if (avs_read) begin
                        st_nxt.rdata = rd;
                    end
                end
            end
            default: begin
                st_nxt.bus = gpp_pkg::BUS_IDLE;
            end
        endcase
        // Open drain drives only low: enable while output data is zero
        for (int i = 0; i < W; i++) begin
            if (st_r.afsel[i]) begin
                st_nxt.pin_out[i] = alt_out[i];
                st_nxt.pin_oe[i] = st_r.odr[i] ? alt_oe[i] & ~alt_out[i] : alt_oe[i];
            end else begin
                st_nxt.pin_out[i] = st_r.data[i];
                st_nxt.pin_oe[i] = st_r.dir[i] & st_r.den[i] & (~st_r.odr[i] | ~st_r.data[i]);
            end
        end
        st_nxt.alt_in = ain & st_r.afsel;
        st_nxt.irq = |msk;
        st_nxt.adc = HAS_ADC_TRIG && msk[gpp_pkg::ADC_TRIG_BIT] && !st_r.adc_prev;
        st_nxt.adc_prev = msk[gpp_pkg::ADC_TRIG_BIT];
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.bus <= gpp_pkg::BUS_IDLE;
            st_r.drv2 <= gpp_pkg::RST_DRV2;
            st_r.afsel <= RST_AFSEL;
            st_r.pur <= RST_PUR;
            st_r.den <= RST_DEN;
            st_r.pdr <= gpp_pkg::RST_ZERO;
            st_r.commit <= RST_COMMIT;
            st_r.locked <= gpp_pkg::LOCKED_VAL[0];
        end else begin
            st_r <= st_nxt;
        end
    end
    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = !(st_r.bus == gpp_pkg::BUS_ACK) && (avs_read || avs_write) || srst;
    assign pin_out = st_r.pin_out;
    assign pin_oe = st_r.pin_oe;
    assign alt_in = st_r.alt_in;
    assign pad_drive_low = st_r.drv2;
    assign pad_drive_mid = st_r.drv4;
    assign pad_drive_high = st_r.drv8;
    assign pad_open_drain = st_r.odr;
    assign pad_pull_up = st_r.pur;
    assign pad_pull_down = st_r.pdr;
    assign pad_slew_limit = st_r.slr;
    assign pad_digital_enable = st_r.den;
    assign port_irq = st_r.irq;
    assign adc_trigger = st_r.adc;
endmodule // gpp_port

// ### tb/gpp_port_checker.sv
// Checker: bus handshake, reset state and pad-output properties of the gpio port
module gpp_port_checker #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pad_drive_low,
    input wire logic [W-1:0] pad_drive_mid,
    input wire logic [W-1:0] pad_drive_high,
    input wire logic [W-1:0] pad_open_drain,
    input wire logic [W-1:0] pad_pull_down,
    input wire logic port_irq,
    input wire logic adc_trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    wait_state_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("request not answered after one wait state");
    ack_bound_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("request waited too long");
    ack_once_a: assert property ((avs_read || avs_write) && !avs_waitrequest |=> avs_waitrequest || !(avs_read || avs_write))
        else $error("second ack without new wait state");
    rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    oe_reset_a: assert property ($past(srst) |-> pin_oe == '0 && !port_irq)
        else $error("pins driven or irq high after reset");
    pad_reset_a: assert property ($past(srst) |-> pad_drive_low == '1 && pad_pull_down == '0 && pad_open_drain == '0)
        else $error("pad settings wrong after reset");
    drive_excl_a: assert property ((pad_drive_low & pad_drive_mid) == '0 && ((pad_drive_low | pad_drive_mid) & pad_drive_high) == '0)
        else $error("two drive strengths on one pin");
    adc_pulse_a: assert property (adc_trigger |=> !adc_trigger)
        else $error("adc trigger longer than one cycle");
    adc_irq_a: assert property (adc_trigger |-> port_irq)
        else $error("adc trigger without port interrupt");
endmodule // gpp_port_checker

bind gpp_port gpp_port_checker #(.W(W)) gpp_port_checker_inst (.core_clk(core_clk), .srst(srst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_oe(pin_oe), .pad_drive_low(pad_drive_low), .pad_drive_mid(pad_drive_mid), .pad_drive_high(pad_drive_high),
    .pad_open_drain(pad_open_drain), .pad_pull_down(pad_pull_down), .port_irq(port_irq), .adc_trigger(adc_trigger));

// ### tb/gpp_pad_model.sv
// Far-side model: external pin sources and the alternate-function peripheral
module gpp_pad_model (
    input wire logic core_clk,
    input wire logic [7:0] want,
    input wire logic [7:0] want_alt,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic [7:0] pin_in,
    output logic [7:0] alt_out,
    output logic [7:0] alt_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial alt_out = 8'h00;
    initial alt_oe = 8'h00;
    // The port wins the wire where it drives; elsewhere a source holds its level until told to change
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = (pin_oe[i] === 1'b1) ? pin_out[i] : want[i];
        end
    end
    always @(posedge core_clk) begin
        alt_out <= want_alt;
        alt_oe <= want_alt;
    end
endmodule // gpp_pad_model

// ### tb/gpp_port_test.sv
// Testbench: registers, masked data, interrupts, commit lock and alternate function of the gpio port
module gpp_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, port_irq, adc_trigger;
    logic [7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in, dlo, dmid, dhi, odr, pu, pd, slr, den;
    logic [7:0] want = 8'h00;
    logic [7:0] want_alt = 8'h00;
    logic [7:0] cur = 8'h00;
    logic [31:0] rnd = 32'h6c923d16;
    logic [31:0] exp_q[$];
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    int adc_pulses = 0;

    always #2.5 core_clk = ~core_clk;

    gpp_port #(.RST_COMMIT(8'h7f), .HAS_ADC_TRIG(1'b1), .IDENT(96'h0102_0304_0506_0708_090a_0b0c)) gpp_port_inst (
        .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
        .pad_drive_low(dlo), .pad_drive_mid(dmid), .pad_drive_high(dhi), .pad_open_drain(odr), .pad_pull_up(pu),
        .pad_pull_down(pd), .pad_slew_limit(slr), .pad_digital_enable(den), .port_irq(port_irq),
        .adc_trigger(adc_trigger));
    gpp_pad_model gpp_pad_model_inst (.core_clk(core_clk), .want(want), .want_alt(want_alt), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in), .alt_out(alt_out), .alt_oe(alt_oe));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Holds the request until waitrequest is seen low, then spends one idle edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge core_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
        if (adc_trigger === 1'b1) adc_pulses++;
        cyc++;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        idle(12);
        srst <= 1'b0;
        rd(gpp_pkg::OFS_DRV2, 32'h0000_00ff);
        rd(gpp_pkg::OFS_AFSEL, 32'h0000_0000);
        rd(gpp_pkg::OFS_LOCK, 32'h0000_0001);
        rd(12'h600, 32'h0000_0000);
        wr(gpp_pkg::OFS_ID_BASE, 32'h0000_00ff);
        rd(gpp_pkg::OFS_ID_BASE, 32'h0000_0001);
        rd(12'hffc, 32'h0000_000c);
        wr(gpp_pkg::OFS_DRV8, 32'h0000_000f);
        rd(gpp_pkg::OFS_DRV2, 32'h0000_00f0);
        chk({24'h0, dhi}, 32'h0000_000f);
        wr(gpp_pkg::OFS_DIR, 32'h0000_00ff);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            cur = (cur & ~rnd[7:0]) | (rnd[15:8] & rnd[7:0]);
            wr({2'b00, rnd[7:0], 2'b00}, {24'h0, rnd[15:8]});
            rd({2'b00, rnd[23:16], 2'b00}, {24'h0, cur & rnd[23:16]});
            chk({24'h0, pin_out}, {24'h0, cur});
        end
        wr(gpp_pkg::OFS_POL, 32'h0000_00ff);
        wr(gpp_pkg::OFS_DEN, 32'h0000_00ff);
        wr(gpp_pkg::OFS_DIR, 32'h0000_0000);
        want <= 8'h5a;
        idle(8);
        rd(gpp_pkg::OFS_DATA_HI, 32'h0000_005a);
        chk({24'h0, pin_oe}, 32'h0000_0000);
        want <= 8'h00;
        idle(8);
        wr(gpp_pkg::OFS_CLR, 32'h0000_00ff);
        wr(gpp_pkg::OFS_MASK, 32'h0000_00f7);
        want <= 8'h1c;
        idle(8);
        rd(gpp_pkg::OFS_RAW, 32'h0000_001c);
        rd(gpp_pkg::OFS_MSTAT, 32'h0000_0014);
        chk({31'h0, port_irq}, 32'h0000_0001);
        want <= 8'h00;
        idle(8);
        rd(gpp_pkg::OFS_RAW, 32'h0000_001c);
        wr(gpp_pkg::OFS_CLR, 32'h0000_0004);
        rd(gpp_pkg::OFS_RAW, 32'h0000_0018);
        wr(gpp_pkg::OFS_CLR, 32'h0000_0018);
        idle(3);
        chk({31'h0, port_irq}, 32'h0000_0000);
        wr(gpp_pkg::OFS_MASK, 32'h0000_0000);
        wr(gpp_pkg::OFS_DUAL, 32'h0000_0001);
        want <= 8'h01;
        idle(8);
        wr(gpp_pkg::OFS_CLR, 32'h0000_0001);
        want <= 8'h00;
        idle(8);
        rd(gpp_pkg::OFS_RAW, 32'h0000_0001);
        wr(gpp_pkg::OFS_CLR, 32'h0000_0001);
        wr(gpp_pkg::OFS_SENSE, 32'h0000_0002);
        want <= 8'h02;
        idle(8);
        wr(gpp_pkg::OFS_CLR, 32'h0000_0002);
        rd(gpp_pkg::OFS_RAW, 32'h0000_0002);
        want <= 8'h00;
        idle(8);
        rd(gpp_pkg::OFS_RAW, 32'h0000_0000);
        wr(gpp_pkg::OFS_AFSEL, 32'h0000_0080);
        rd(gpp_pkg::OFS_AFSEL, 32'h0000_0000);
        wr(gpp_pkg::OFS_LOCK, gpp_pkg::UNLOCK_KEY);
        wr(gpp_pkg::OFS_COMMIT, 32'h0000_00ff);
        wr(gpp_pkg::OFS_AFSEL, 32'h0000_0080);
        rd(gpp_pkg::OFS_AFSEL, 32'h0000_0080);
        want_alt <= 8'h80;
        idle(8);
        chk({24'h0, pin_oe}, 32'h0000_0080);
        chk({30'h0, pin_out[7], alt_in[7]}, 32'h0000_0003);
        wr(gpp_pkg::OFS_LOCK, 32'h0000_0000);
        rd(gpp_pkg::OFS_LOCK, 32'h0000_0001);
        chk(32'(adc_pulses), 32'h0000_0001);
        tally_and_finish();
    end
endmodule // gpp_port_test
